// ---- common/frt_pkg.sv ----
// Package: register map, field positions, reset values and count-source codes
package frt_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL_STATUS = 8'h00;
    localparam logic [7:0] OFF_COUNTER = 8'h04;
    localparam logic [7:0] OFF_COMPARE = 8'h08;
    localparam logic [7:0] OFF_CAPTURE_A = 8'h0c;
    localparam logic [7:0] OFF_CAPTURE_B = 8'h10;
    localparam logic [7:0] OFF_CAPTURE_C = 8'h14;
    localparam logic [7:0] OFF_CAPTURE_D = 8'h18;
    localparam logic [7:0] OFF_TIMER_CONTROL = 8'h1c;
    localparam logic [7:0] OFF_COMPARE_OUTPUT_CONTROL = 8'h20;
    localparam logic [7:0] OFF_MODULE_STOP_CONTROL = 8'h24;

    // ----------------------------------------------------------------
    // Control/status fields (flags are 7..1)
    // ----------------------------------------------------------------
    localparam int FLAG_CAPTURE_A = 7;
    localparam int FLAG_COMPARE_A = 3;
    localparam int FLAG_COMPARE_B = 2;
    localparam int FLAG_OVERFLOW = 1;
    localparam int BIT_CLEAR_ON_MATCH_A = 0;

    // ----------------------------------------------------------------
    // Timer control fields
    // ----------------------------------------------------------------
    localparam int BIT_EDGE_A = 7;
    localparam int BIT_BUFFER_ENABLE_A = 3;
    localparam int BIT_BUFFER_ENABLE_B = 2;
    localparam int BIT_CLOCK_SELECT_HI = 1;
    localparam int BIT_CLOCK_SELECT_LO = 0;

    // ----------------------------------------------------------------
    // Compare output control fields
    // ----------------------------------------------------------------
    localparam int BIT_CAPTURE_D_MASK_MODE = 7;
    localparam int BIT_COMPARE_A_AUTOADD_MODE = 6;
    localparam int BIT_CAPTURE_REG_SELECT = 5;
    localparam int BIT_COMPARE_REG_SELECT = 4;
    localparam int BIT_COMPARE_OUT_A_ENABLE = 3;
    localparam int BIT_COMPARE_OUT_B_ENABLE = 2;
    localparam int BIT_COMPARE_OUT_A_LEVEL = 1;
    localparam int BIT_COMPARE_OUT_B_LEVEL = 0;

    // Module stop bit for this timer
    localparam int BIT_TIMER_MODULE_STOP = 13;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RESET_COMPARE_OUTPUT_CONTROL = 8'h00;
    localparam logic [7:0] RESET_TIMER_CONTROL = 8'h00;
    localparam logic [15:0] RESET_MODULE_STOP_CONTROL = 16'h3fff;
    localparam logic [15:0] RESET_COMPARE = 16'hffff;
    localparam logic [15:0] COUNTER_MAX = 16'hffff;

    // ----------------------------------------------------------------
    // Count source codes and prescaler taps
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_DIV2 = 2'b00,
        SRC_DIV8 = 2'b01,
        SRC_DIV32 = 2'b10,
        SRC_EXTERNAL = 2'b11
    } count_source_t;

    localparam logic [4:0] PRESCALE_DIV2_MASK = 5'h01;
    localparam logic [4:0] PRESCALE_DIV8_MASK = 5'h07;
    localparam logic [4:0] PRESCALE_DIV32_MASK = 5'h1f;

endpackage : frt_pkg

// ---- dv/frcc_props.sv ----
// Checker: port-level properties of the capture/compare timer
`timescale 1ns/1ps
module frcc_props (
    // Bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // System and pins
    input wire logic hw_standby,
    input wire logic compare_out_a_pin,
    input wire logic compare_out_a_oe_n,
    input wire logic compare_out_b_pin,
    input wire logic compare_out_b_oe_n
);
    logic wc;
    logic rs;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Standby overrides a write, so it is kept out of the write case
    assign wc = psel && penable && pwrite && !hw_standby && paddr == 8'h20;
    assign rs = psel && !penable && !pwrite;
    property p_oe_a; wc |=> compare_out_a_oe_n == !$past(pwdata[3]); endproperty
    a_oe_a: assert property (p_oe_a) else $error("enable a");
    property p_oe_b; wc |=> compare_out_b_oe_n == !$past(pwdata[2]); endproperty
    a_oe_b: assert property (p_oe_b) else $error("enable b");
    property p_sby_oe; hw_standby |=> compare_out_a_oe_n && compare_out_b_oe_n; endproperty
    a_sby_oe: assert property (p_sby_oe) else $error("standby enables");
    property p_ctl_sby; rs && paddr == 8'h20 && $past(hw_standby) |=> prdata == 32'h0; endproperty
    a_ctl_sby: assert property (p_ctl_sby) else $error("standby control");
    property p_ms_sby; rs && paddr == 8'h24 && $past(hw_standby) |=> prdata == 32'h3fff; endproperty
    a_ms_sby: assert property (p_ms_sby) else $error("standby stop");
    property p_ctl_w; rs && paddr == 8'h20 |=> prdata[31:8] == 24'h0; endproperty
    a_ctl_w: assert property (p_ctl_w) else $error("control width");
    property p_ms_w; rs && paddr == 8'h24 |=> prdata[31:16] == 16'h0; endproperty
    a_ms_w: assert property (p_ms_w) else $error("stop width");
    property p_frz; hw_standby ##1 hw_standby
        |=> $stable(compare_out_a_pin) && $stable(compare_out_b_pin); endproperty
    a_frz: assert property (p_frz) else $error("pins moved");
endmodule : frcc_props

bind free_running_capture_compare frcc_props u_props (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .hw_standby, .compare_out_a_pin,
    .compare_out_a_oe_n, .compare_out_b_pin, .compare_out_b_oe_n);

// ---- dv/pin_model.sv ----
// Partner: far-side drivers of the external clock and capture pins
`timescale 1ns/1ps
module pin_model (
    // Clock
    input wire logic pclk,
    // Pins toward the timer
    output logic ext_clk_pin,
    output logic [3:0] capture_in_pins
);
    initial
    begin
        ext_clk_pin = 1'b0;
        capture_in_pins = 4'h0;
    end
    // Two cycles high and low: clear of the 1.5-cycle minimum width
    task ext_pulses(input int n);
        repeat (n)
        begin
            ext_clk_pin <= 1'b1;
            repeat (2) @(posedge pclk);
            ext_clk_pin <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask : ext_pulses
    task cap(input int ch, input logic lvl);
        capture_in_pins[ch] <= lvl;
        repeat (2) @(posedge pclk);
    endtask : cap
endmodule : pin_model

// ---- dv/tb_top.sv ----
// Testbench: scenarios for the capture/compare timer
`timescale 1ns/1ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hw_standby, ext_clk_pin;
    logic compare_out_a_pin, compare_out_a_oe_n, compare_out_b_pin, compare_out_b_oe_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, v;
    logic [3:0] capture_in_pins;
    int fails, checked, i;
    always #10 pclk = ~pclk;
    free_running_capture_compare DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .hw_standby, .ext_clk_pin, .capture_in_pins,
        .compare_out_a_pin, .compare_out_a_oe_n, .compare_out_b_pin, .compare_out_b_oe_n);
    pin_model PM (.pclk, .ext_clk_pin, .capture_in_pins);
    task results;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // ----------------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------------
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50 && pready !== 1'b1; n++)
            @(posedge pclk);
        if (n == 50)
        begin
            fails++;
            results();
        end
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task wt(input logic b, input logic lvl);
        int n;
        for (n = 0; n < 300 && (b ? compare_out_b_pin : compare_out_a_pin) !== lvl; n++)
            @(posedge pclk);
        chk(32'(b ? compare_out_b_pin : compare_out_a_pin), 32'(lvl));
    endtask : wt
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, hw_standby, paddr, pwdata} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h20);
        chk(r, 32'h0);
        rd(8'h24);
        chk(r, 32'h3fff);
        $display("reset test done");
        // Compare B then A at the shared address
        wr(8'h00, 32'h1);
        wr(8'h20, 32'h1d);
        wr(8'h08, 32'h3);
        wr(8'h20, 32'h0f);
        wr(8'h08, 32'h5);
        rd(8'h08);
        chk(r, 32'h5);
        wr(8'h20, 32'h1f);
        rd(8'h08);
        chk(r, 32'h3);
        chk(32'({compare_out_a_oe_n, compare_out_b_oe_n}), 32'h0);
        wr(8'h24, 32'h0);
        wt(1'b0, 1'b1);
        wt(1'b1, 1'b1);
        wr(8'h20, 32'h0c);
        wt(1'b0, 1'b0);
        wt(1'b1, 1'b0);
        rd(8'h00);
        chk(r & 32'hd, 32'hd);
        rd(8'h04);
        chk(32'(r < 32'h6), 32'h1);
        $display("compare test done");
        wr(8'h1c, 32'h3);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0);
        PM.ext_pulses(3);
        rd(8'h04);
        chk(r, 32'h3);
        // Rising edges on A, C as buffer
        wr(8'h1c, 32'h8b);
        wr(8'h04, 32'h10);
        PM.cap(0, 1'b1);
        PM.ext_pulses(2);
        PM.cap(0, 1'b0);
        PM.ext_pulses(1);
        PM.cap(0, 1'b1);
        rd(8'h0c);
        chk(r, 32'h13);
        rd(8'h14);
        chk(r, 32'h10);
        rd(8'h00);
        chk(32'(r[7:4]), 32'h8);
        PM.cap(2, 1'b1);
        PM.cap(2, 1'b0);
        rd(8'h00);
        chk(32'(r[7:4]), 32'ha);
        rd(8'h14);
        chk(r, 32'h10);
        wr(8'h20, 32'h2c);
        wr(8'h0c, 32'h1234);
        rd(8'h0c);
        chk(r, 32'h1234);
        wr(8'h20, 32'h0c);
        rd(8'h0c);
        chk(r, 32'h13);
        $display("capture test done");
        wr(8'h1c, 32'h0);
        wr(8'h04, 32'hffff);
        wr(8'h24, 32'h2000);
        rd(8'h04);
        v = r;
        repeat (20) @(posedge pclk);
        rd(8'h04);
        chk(r, v);
        rd(8'h00);
        chk(r & 32'h2, 32'h2);
        wr(8'h24, 32'h0);
        repeat (20) @(posedge pclk);
        rd(8'h04);
        chk(32'(r != v), 32'h1);
        for (i = 0; i < 2; i++)
        begin
            hw_standby <= 1'b1;
            repeat (2) @(posedge pclk);
            hw_standby <= 1'b0;
            rd(i ? 8'h24 : 8'h20);
            chk(r, i ? 32'h3fff : 32'h0);
        end
        chk(32'({compare_out_a_oe_n, compare_out_b_oe_n}), 32'h3);
        $display("stop test done");
        results();
    end
endmodule : tb_top

// ---- verilog/count_source.sv ----
// Count source: internal prescaler taps or external clock rising edges
`timescale 1ns/1ps
module count_source (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    input wire logic [1:0] clock_select,
    input wire logic ext_clk,
    // One-cycle count enable
    output logic count_tick
);

    logic [4:0] prescale_reg;
    logic ext_prev_reg;
    logic [4:0] mask;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prescale_reg <= 5'h00;
        else
            prescale_reg <= prescale_reg + 5'h01;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ext_prev_reg <= 1'b0;
        else
            ext_prev_reg <= ext_clk;
    end

    // Tick once per period of the chosen divided clock [R11] [R21]
    always_comb
    begin
        case (frt_pkg::count_source_t'(clock_select))
            frt_pkg::SRC_DIV2: mask = frt_pkg::PRESCALE_DIV2_MASK;
            frt_pkg::SRC_DIV8: mask = frt_pkg::PRESCALE_DIV8_MASK;
            frt_pkg::SRC_DIV32: mask = frt_pkg::PRESCALE_DIV32_MASK;
            default: mask = frt_pkg::PRESCALE_DIV2_MASK;
        endcase
    end

    // External source counts rising edges; pulses of 1.5 cycles are always seen [R12]
    always_comb
    begin
        if (!run)
            count_tick = 1'b0;
        else if (clock_select == frt_pkg::SRC_EXTERNAL)
            count_tick = ext_clk & ~ext_prev_reg;
        else
            count_tick = ((prescale_reg & mask) == mask);
    end

endmodule : count_source

// ---- verilog/free_running_capture_compare.sv ----
// Free-running 16-bit timer with two compare outputs and four capture inputs
`timescale 1ns/1ps
// What this block does
// R1: Output control register clears on reset, standby
// R2: Bit 7 enables mask of capture D
// R3: Bit 6 enables compare A auto-add
// R4: Bit 5 steers shared capture addresses
// R5: Bit 4 steers shared compare address
// R6: Outputs driven only while enables set
// R7: Level A applied at match A, toggled instead in auto-add
// R8: Level B applied at match B
// R9: Module stop halts timer, zero resumes
// R10: Module stop register resets to 3fff
// R11: Counter advances once per source period
// R12: External clock pulses at least 1.5 cycles
// R13: Compare match drives pin to level, A toggles in auto-add
// R14: Optional counter clear on match A
// R15: Edge select picks capture edge, 1 rising
// R16: Upper-byte read delays capture one cycle
// R17: C and D buffer A and B
// R18: Buffer channel edge sets flag only
// R19: Read of either pair delays capture
// R20: Capture sets flag, loads counter together
// R21: Clock select chooses divider or external
// R22: Match in last equal state, sets flag
// R23: Overflow flag on wrap to zero
// R24: Buffer enables pair C-A, D-B
// R25: Buffered capture shifts old value down
// R26: Full 16-bit equality compare each state
module free_running_capture_compare (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System
    input wire logic hw_standby,
    // Timer pins
    input wire logic ext_clk_pin,
    input wire logic [3:0] capture_in_pins,
    output logic compare_out_a_pin,
    output logic compare_out_a_oe_n,
    output logic compare_out_b_pin,
    output logic compare_out_b_oe_n
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] compare_output_control_reg;
    logic [15:0] module_stop_control_reg;
    logic [7:0] timer_control_reg;
    logic [7:0] status_reg;
    logic [15:0] counter_reg;
    logic [15:0] compare_a_reg;
    logic [15:0] compare_b_reg;
    logic [15:0] rise_increment_reg;
    logic [15:0] fall_increment_reg;
    logic [15:0] mask_interval_reg;
    logic [15:0] capture_a_reg;
    logic [15:0] capture_b_reg;
    logic [15:0] capture_c_reg;
    logic [15:0] capture_d_reg;
    logic [3:0] pin_prev_reg;
    logic [3:0] pending_reg;
    logic compare_written_reg;
    logic mask_active_reg;
    logic out_a_reg;
    logic out_b_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic stopped;
    logic tick;
    logic wr;
    logic capture_sel;
    logic compare_sel;
    logic buf_a;
    logic buf_b;
    logic [3:0] raw_event;
    logic [3:0] hold;
    logic [3:0] fire;
    logic match_a;
    logic match_b;
    logic wr_compare;
    logic clear_counter;
    logic overflow;
    logic [6:0] flag_set;
    logic [15:0] mask_end;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
        hit = (addr == offset);
    endfunction : hit

    function automatic logic edge_seen(input logic prev, input logic now, input logic rising);
        edge_seen = rising ? (now & ~prev) : (prev & ~now);
    endfunction : edge_seen

    assign stopped = module_stop_control_reg[frt_pkg::BIT_TIMER_MODULE_STOP]; // [R9]
    assign wr = psel & penable & pwrite;
    assign capture_sel = compare_output_control_reg[frt_pkg::BIT_CAPTURE_REG_SELECT];
    assign compare_sel = compare_output_control_reg[frt_pkg::BIT_COMPARE_REG_SELECT];
    assign buf_a = timer_control_reg[frt_pkg::BIT_BUFFER_ENABLE_A]; // [R24]
    assign buf_b = timer_control_reg[frt_pkg::BIT_BUFFER_ENABLE_B]; // [R24]

    count_source u_count_source (
        .pclk(pclk),
        .presetn(presetn),
        .run(~stopped),
        .clock_select({timer_control_reg[frt_pkg::BIT_CLOCK_SELECT_HI],
                       timer_control_reg[frt_pkg::BIT_CLOCK_SELECT_LO]}),
        .ext_clk(ext_clk_pin),
        .count_tick(tick)
    );

    // ----------------------------------------------------------------
    // Capture events
    // ----------------------------------------------------------------
    // A read of a capture register spans setup and access phases
    always_comb
    begin
        hold[0] = psel & ~pwrite & ~capture_sel & hit(paddr, frt_pkg::OFF_CAPTURE_A);
        hold[1] = psel & ~pwrite & ~capture_sel & hit(paddr, frt_pkg::OFF_CAPTURE_B);
        hold[2] = psel & ~pwrite & ~capture_sel & hit(paddr, frt_pkg::OFF_CAPTURE_C);
        hold[3] = psel & ~pwrite & hit(paddr, frt_pkg::OFF_CAPTURE_D); // [R16]
        if (buf_a)
        begin
            hold[0] = hold[0] | hold[2]; // [R19]
        end
        if (buf_b)
        begin
            hold[1] = hold[1] | hold[3]; // [R19]
        end
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            raw_event[i] = ~stopped & edge_seen(pin_prev_reg[i], capture_in_pins[i],
                timer_control_reg[frt_pkg::BIT_EDGE_A - i]); // [R15]
        end
        // Capture D input is ignored while the mask window is open
        if (mask_active_reg)
        begin
            raw_event[3] = 1'b0; // [R2]
        end
        fire = (raw_event & ~hold) | pending_reg; // [R16]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_prev_reg <= 4'h0;
            pending_reg <= 4'h0;
        end
        else
        begin
            pin_prev_reg <= capture_in_pins;
            pending_reg <= raw_event & hold; // [R16] [R19]
        end
    end

    // Capture D mask window, from capture D until counter reaches D plus twice interval
    assign mask_end = capture_d_reg + {mask_interval_reg[14:0], 1'b0};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_active_reg <= 1'b0;
        else if (!compare_output_control_reg[frt_pkg::BIT_CAPTURE_D_MASK_MODE])
            mask_active_reg <= 1'b0;
        else if (fire[3] && mask_interval_reg != 16'h0000)
            mask_active_reg <= 1'b1; // [R2]
        else if (tick && counter_reg == mask_end)
            mask_active_reg <= 1'b0; // [R2]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            capture_a_reg <= 16'h0000;
            capture_b_reg <= 16'h0000;
            capture_c_reg <= 16'h0000;
            capture_d_reg <= 16'h0000;
        end
        else
        begin
            if (fire[0])
            begin
                capture_a_reg <= counter_reg; // [R20]
                if (buf_a)
                    capture_c_reg <= capture_a_reg; // [R17] [R25]
            end
            if (fire[1])
            begin
                capture_b_reg <= counter_reg; // [R20]
                if (buf_b)
                    capture_d_reg <= capture_b_reg; // [R17] [R25]
            end
            // Buffer channels keep their own edge for the flag only
            if (fire[2] && !buf_a)
                capture_c_reg <= counter_reg; // [R18]
            if (fire[3] && !buf_b)
                capture_d_reg <= counter_reg; // [R18]
        end
    end

    // ----------------------------------------------------------------
    // Counter and compare
    // ----------------------------------------------------------------
    assign wr_compare = wr & (hit(paddr, frt_pkg::OFF_COMPARE)
        | (capture_sel & (hit(paddr, frt_pkg::OFF_CAPTURE_A)
        | hit(paddr, frt_pkg::OFF_CAPTURE_B))));

    // A compare write wins over a match in its own cycle and the following cycle
    assign match_a = tick & ~wr_compare & ~compare_written_reg
        & (counter_reg == compare_a_reg); // [R22] [R26]
    assign match_b = tick & ~wr_compare & ~compare_written_reg
        & (counter_reg == compare_b_reg); // [R22] [R26]
    assign clear_counter = match_a & status_reg[frt_pkg::BIT_CLEAR_ON_MATCH_A]; // [R14]
    assign overflow = tick & ~clear_counter & ~(wr & hit(paddr, frt_pkg::OFF_COUNTER))
        & (counter_reg == frt_pkg::COUNTER_MAX);
    assign flag_set = {fire[0], fire[1], fire[2], fire[3], match_a, match_b, overflow};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            compare_written_reg <= 1'b0;
        else
            compare_written_reg <= wr_compare;
    end

    // Clear beats a software write, which beats an increment
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            counter_reg <= 16'h0000;
        else if (clear_counter)
            counter_reg <= 16'h0000; // [R14]
        else if (wr && hit(paddr, frt_pkg::OFF_COUNTER))
            counter_reg <= pwdata[15:0];
        else if (tick)
            counter_reg <= counter_reg + 16'h0001; // [R11]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            compare_a_reg <= frt_pkg::RESET_COMPARE;
            compare_b_reg <= frt_pkg::RESET_COMPARE;
            rise_increment_reg <= frt_pkg::RESET_COMPARE;
            fall_increment_reg <= frt_pkg::RESET_COMPARE;
            mask_interval_reg <= 16'h0000;
        end
        else if (wr)
        begin
            if (hit(paddr, frt_pkg::OFF_COMPARE) && !compare_sel)
                compare_a_reg <= pwdata[15:0]; // [R5]
            if (hit(paddr, frt_pkg::OFF_COMPARE) && compare_sel)
                compare_b_reg <= pwdata[15:0]; // [R5]
            if (hit(paddr, frt_pkg::OFF_CAPTURE_A) && capture_sel)
                rise_increment_reg <= pwdata[15:0]; // [R4]
            if (hit(paddr, frt_pkg::OFF_CAPTURE_B) && capture_sel)
                fall_increment_reg <= pwdata[15:0]; // [R4]
            if (hit(paddr, frt_pkg::OFF_CAPTURE_C) && capture_sel)
                mask_interval_reg <= pwdata[15:0]; // [R4]
        end
        else if (match_a && compare_output_control_reg[frt_pkg::BIT_COMPARE_A_AUTOADD_MODE])
        begin
            // Going high adds the rise increment, going low the fall increment
            compare_a_reg <= compare_a_reg
                + (out_a_reg ? fall_increment_reg : rise_increment_reg); // [R3]
        end
    end

    // ----------------------------------------------------------------
    // Compare outputs
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_a_reg <= 1'b0;
            out_b_reg <= 1'b0;
        end
        else
        begin
            if (match_a)
            begin
                if (compare_output_control_reg[frt_pkg::BIT_COMPARE_A_AUTOADD_MODE])
                    out_a_reg <= ~out_a_reg; // [R3] [R7]
                else
                    out_a_reg <= compare_output_control_reg[frt_pkg::BIT_COMPARE_OUT_A_LEVEL]; // [R7] [R13]
            end
            if (match_b)
                out_b_reg <= compare_output_control_reg[frt_pkg::BIT_COMPARE_OUT_B_LEVEL]; // [R8] [R13]
        end
    end

    assign compare_out_a_pin = out_a_reg;
    assign compare_out_b_pin = out_b_reg;
    assign compare_out_a_oe_n =
        ~compare_output_control_reg[frt_pkg::BIT_COMPARE_OUT_A_ENABLE]; // [R6]
    assign compare_out_b_oe_n =
        ~compare_output_control_reg[frt_pkg::BIT_COMPARE_OUT_B_ENABLE]; // [R6]

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            compare_output_control_reg <= frt_pkg::RESET_COMPARE_OUTPUT_CONTROL; // [R1]
            module_stop_control_reg <= frt_pkg::RESET_MODULE_STOP_CONTROL; // [R10]
            timer_control_reg <= frt_pkg::RESET_TIMER_CONTROL;
        end
        else if (hw_standby)
        begin
            compare_output_control_reg <= frt_pkg::RESET_COMPARE_OUTPUT_CONTROL; // [R1]
            module_stop_control_reg <= frt_pkg::RESET_MODULE_STOP_CONTROL; // [R10]
            timer_control_reg <= frt_pkg::RESET_TIMER_CONTROL;
        end
        else if (wr)
        begin
            if (hit(paddr, frt_pkg::OFF_COMPARE_OUTPUT_CONTROL))
                compare_output_control_reg <= pwdata[7:0];
            // Stop takes hold once this bus cycle completes
            if (hit(paddr, frt_pkg::OFF_MODULE_STOP_CONTROL))
                module_stop_control_reg <= pwdata[15:0]; // [R9]
            if (hit(paddr, frt_pkg::OFF_TIMER_CONTROL))
                timer_control_reg <= pwdata[7:0];
        end
    end

    // Flags: write 0 clears, writing 1 has no effect, a set in the same cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_reg <= 8'h00;
        else
        begin
            if (wr && hit(paddr, frt_pkg::OFF_CTRL_STATUS))
            begin
                status_reg[7:1] <= (status_reg[7:1] & pwdata[7:1])
                    | flag_set; // [R20] [R22] [R23]
                status_reg[frt_pkg::BIT_CLEAR_ON_MATCH_A] <= pwdata[frt_pkg::BIT_CLEAR_ON_MATCH_A];
            end
            else
                status_reg[7:1] <= status_reg[7:1]
                    | flag_set; // [R18] [R20] [R22] [R23]
        end
    end

    // ----------------------------------------------------------------
    // APB read path, latched in the setup phase
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            case (paddr)
                frt_pkg::OFF_CTRL_STATUS: prdata_reg[7:0] <= status_reg;
                frt_pkg::OFF_COUNTER: prdata_reg[15:0] <= counter_reg;
                frt_pkg::OFF_COMPARE:
                    prdata_reg[15:0] <= compare_sel ? compare_b_reg : compare_a_reg; // [R5]
                frt_pkg::OFF_CAPTURE_A:
                    prdata_reg[15:0] <= capture_sel ? rise_increment_reg : capture_a_reg; // [R4]
                frt_pkg::OFF_CAPTURE_B:
                    prdata_reg[15:0] <= capture_sel ? fall_increment_reg : capture_b_reg; // [R4]
                frt_pkg::OFF_CAPTURE_C:
                    prdata_reg[15:0] <= capture_sel ? mask_interval_reg : capture_c_reg; // [R4]
                frt_pkg::OFF_CAPTURE_D: prdata_reg[15:0] <= capture_d_reg;
                frt_pkg::OFF_TIMER_CONTROL: prdata_reg[7:0] <= timer_control_reg;
                frt_pkg::OFF_COMPARE_OUTPUT_CONTROL:
                    prdata_reg[7:0] <= compare_output_control_reg;
                frt_pkg::OFF_MODULE_STOP_CONTROL: prdata_reg[15:0] <= module_stop_control_reg;
                default: pslverr_reg <= 1'b1;
            endcase
        end
    end

    assign prdata = prdata_reg;
    assign pready = psel & penable;
    assign pslverr = pslverr_reg & psel & penable;

endmodule : free_running_capture_compare
